// [rtl/pfcr_func_reg.sv]
`timescale 1ns/10ps
`include "pfcr_params.svh"

module pfcr_func_reg (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Configuration write to this function's control dword
	input wire logic wr_i,
	input wire logic [3:0] byte_en_i,
	input wire logic [31:0] wdata_i,
	// Hardware event
	input wire logic dpar_set_i,
	// State
	output pfcr_pkg::pfcr_cmd_t cmd_o,
	output logic dpar_flag_o
);

	logic [15:0] cmd;
	logic [15:0] next_cmd;
	logic dpar_flag;
	logic next_dpar_flag;
	logic dpar_clear;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_cmd = cmd;
		if (wr_i) begin
			if (byte_en_i[0]) begin
				next_cmd[7:0] = wdata_i[7:0] & 8'(`PFCR_CMD_WRITABLE_MASK);
			end
			if (byte_en_i[1]) begin
				next_cmd[15:8] = wdata_i[15:8] & 8'(`PFCR_CMD_WRITABLE_MASK >> 8);
			end
		end
		// Write one clears; a same-cycle event still sets
		dpar_clear = wr_i & byte_en_i[3] & wdata_i[16 + `PFCR_STATUS_DPAR_BIT];
		next_dpar_flag = dpar_set_i | (dpar_flag & ~dpar_clear);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd <= `PFCR_CMD_RESET;
			dpar_flag <= 1'b0;
		end else begin
			cmd <= next_cmd;
			dpar_flag <= next_dpar_flag;
		end
	end

	assign cmd_o = pfcr_pkg::pfcr_cmd_t'(cmd);
	assign dpar_flag_o = dpar_flag;

endmodule

// [rtl/pfcr_params.svh]
`ifndef PFCR_PARAMS_SVH
`define PFCR_PARAMS_SVH

// Configuration dword that holds control (low half) and status (high half)
`define PFCR_CMD_OFFSET 8'h04
`define PFCR_CMD_RESET 16'h0000
`define PFCR_STATUS_RESET 16'h0000

// Control field positions
`define PFCR_BIT_IO 0
`define PFCR_BIT_MEM 1
`define PFCR_BIT_INITIATOR 2
`define PFCR_BIT_SPECIAL 3
`define PFCR_BIT_INVALIDATE 4
`define PFCR_BIT_SNOOP 5
`define PFCR_BIT_PARITY 6
`define PFCR_BIT_STEPPING 7
`define PFCR_BIT_SYSERR 8
`define PFCR_BIT_BACK_TO_BACK 9

// Only bits 8, 6, 5, 2, 1, 0 store; all others read zero
`define PFCR_CMD_WRITABLE_MASK 16'h0167

// Data parity flag position inside the status half
`define PFCR_STATUS_DPAR_BIT 8

`endif

// [rtl/pfcr_pkg.sv]
package pfcr_pkg;

	// One configuration access from the bus target logic
	typedef struct packed {
		logic write;
		logic read;
		logic [3:0] func;
		logic [7:0] offset;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} pfcr_cfg_req_t;

	// Per-function view of the control register
	typedef struct packed {
		logic [5:0] reserved;
		logic back_to_back_enable;
		logic system_error_driver_enable;
		logic stepping_enable;
		logic parity_response_enable;
		logic palette_snoop_enable;
		logic write_invalidate_enable;
		logic special_cycle_enable;
		logic bus_initiator_enable;
		logic mem_enable;
		logic io_enable;
	} pfcr_cmd_t;

endpackage

// [rtl/pfcr_top.sv]
`timescale 1ns/10ps
`include "pfcr_params.svh"

// Notes on behaviour
// - Each function keeps its own control register
// - Error enables read per function, act ORed
// - Bits 15 to 10 always read zero
// - Back-to-back enable bit 9 reads zero
// - Bit 8 gates the system-error driver
// - Address parity needs bits 8 and 6
// - Address parity error may assert system-error
// - Bit 6 enables parity-error and system-error reporting
// - Stepping bit 7 hardwired zero, writes ignored
// - Snoop bit 5: capture palette writes unclaimed
// - Write-invalidate bit 4 hardwired zero
// - Special-cycle bit 3 zero, never respond
// - Bus mastering only while bit 2 set
// - Memory claims only while bit 1 set
// - I/O claims only while bit 0 set
// - Data parity flag needs own mastering, bit 6

module pfcr_top #(
	parameter int NUM_FUNC = 2
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Configuration access
	input pfcr_pkg::pfcr_cfg_req_t cfg_req_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	// Per-function decode and master requests
	input wire logic [NUM_FUNC-1:0] io_hit_i,
	input wire logic [NUM_FUNC-1:0] mem_hit_i,
	input wire logic [NUM_FUNC-1:0] palette_write_i,
	input wire logic [NUM_FUNC-1:0] master_req_i,
	input wire logic [NUM_FUNC-1:0] master_active_i,
	// Error detection
	input wire logic addr_parity_err_i,
	input wire logic [NUM_FUNC-1:0] data_parity_err_i,
	input wire logic perr_seen_i,
	// Per-function gated outputs
	output logic [NUM_FUNC-1:0] io_claim_o,
	output logic [NUM_FUNC-1:0] mem_claim_o,
	output logic [NUM_FUNC-1:0] palette_capture_o,
	output logic [NUM_FUNC-1:0] bus_request_o,
	output logic [NUM_FUNC-1:0] write_invalidate_o,
	// Open-drain error pins
	output logic serr_n_o,
	output logic serr_oe_n_o,
	output logic perr_n_o,
	output logic perr_oe_n_o
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic pfcr_is_cmd(input logic [7:0] offset);
		pfcr_is_cmd = (offset[7:2] == 6'(`PFCR_CMD_OFFSET >> 2));
	endfunction

	function automatic logic pfcr_func_sel(input logic [3:0] func, input int idx);
		pfcr_func_sel = (func == 4'(idx));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Per-function registers

	pfcr_pkg::pfcr_cmd_t cmd [NUM_FUNC];
	logic [NUM_FUNC-1:0] dpar_flag;
	logic [NUM_FUNC-1:0] func_wr;
	logic [NUM_FUNC-1:0] dpar_set;
	logic [NUM_FUNC-1:0] parity_bits;
	logic [NUM_FUNC-1:0] syserr_bits;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FUNC; gi++) begin : g_func
			// Separate instance per function; nothing crosses between copies
			assign func_wr[gi] = cfg_req_i.write & pfcr_is_cmd(cfg_req_i.offset)
				& pfcr_func_sel(cfg_req_i.func, gi);
			// Any device's PERR during our own mastered transfer
			assign dpar_set[gi] = perr_seen_i & master_active_i[gi]
				& cmd[gi].parity_response_enable;
			assign parity_bits[gi] = cmd[gi].parity_response_enable;
			assign syserr_bits[gi] = cmd[gi].system_error_driver_enable;

			pfcr_func_reg u_func_reg (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n_i),
				.wr_i(func_wr[gi]),
				.byte_en_i(cfg_req_i.byte_en),
				.wdata_i(cfg_req_i.wdata),
				.dpar_set_i(dpar_set[gi]),
				.cmd_o(cmd[gi]),
				.dpar_flag_o(dpar_flag[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Shared error enables

	logic parity_any;
	logic syserr_any;

	assign parity_any = |parity_bits;
	assign syserr_any = |syserr_bits;

	////////////////////////////////////////////////////////////////////////////
	// Configuration read path

	logic cfg_ack;
	logic next_cfg_ack;
	logic [31:0] cfg_rdata;
	logic [31:0] next_cfg_rdata;

	always_comb begin
		next_cfg_ack = cfg_req_i.read | cfg_req_i.write;
		next_cfg_rdata = cfg_rdata;
		if (cfg_req_i.read) begin
			// Unmapped offsets and absent functions read zero
			next_cfg_rdata = 32'h00000000;
			for (int f = 0; f < NUM_FUNC; f++) begin
				if (pfcr_is_cmd(cfg_req_i.offset) && pfcr_func_sel(cfg_req_i.func, f)) begin
					next_cfg_rdata[15:0] = 16'(cmd[f]);
					next_cfg_rdata[31:16] = `PFCR_STATUS_RESET;
					next_cfg_rdata[16 + `PFCR_STATUS_DPAR_BIT] = dpar_flag[f];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end else begin
			cfg_ack <= next_cfg_ack;
			cfg_rdata <= next_cfg_rdata;
		end
	end

	assign cfg_ack_o = cfg_ack;
	assign cfg_rdata_o = cfg_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Claim and master gating

	logic [NUM_FUNC-1:0] io_claim;
	logic [NUM_FUNC-1:0] next_io_claim;
	logic [NUM_FUNC-1:0] mem_claim;
	logic [NUM_FUNC-1:0] next_mem_claim;
	logic [NUM_FUNC-1:0] palette_capture;
	logic [NUM_FUNC-1:0] next_palette_capture;
	logic [NUM_FUNC-1:0] bus_request;
	logic [NUM_FUNC-1:0] next_bus_request;
	logic [NUM_FUNC-1:0] write_invalidate;
	logic [NUM_FUNC-1:0] next_write_invalidate;

	always_comb begin
		for (int f = 0; f < NUM_FUNC; f++) begin
			// Palette writes live in I/O space; snooping takes them unclaimed
			next_io_claim[f] = cmd[f].io_enable & (io_hit_i[f] | palette_write_i[f])
				& ~(palette_write_i[f] & cmd[f].palette_snoop_enable);
			next_palette_capture[f] = palette_write_i[f]
				& cmd[f].palette_snoop_enable;
			next_mem_claim[f] = cmd[f].mem_enable & mem_hit_i[f];
			next_bus_request[f] = cmd[f].bus_initiator_enable & master_req_i[f];
			// Stored bit is always zero, so masters use plain memory writes
			next_write_invalidate[f] = cmd[f].write_invalidate_enable;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_claim <= '0;
			mem_claim <= '0;
			palette_capture <= '0;
			bus_request <= '0;
			write_invalidate <= '0;
		end else begin
			io_claim <= next_io_claim;
			mem_claim <= next_mem_claim;
			palette_capture <= next_palette_capture;
			bus_request <= next_bus_request;
			write_invalidate <= next_write_invalidate;
		end
	end

	assign io_claim_o = io_claim;
	assign mem_claim_o = mem_claim;
	assign palette_capture_o = palette_capture;
	assign bus_request_o = bus_request;
	assign write_invalidate_o = write_invalidate;

	////////////////////////////////////////////////////////////////////////////
	// Error pin drivers

	logic serr_drive;
	logic next_serr_drive;
	logic perr_drive;
	logic next_perr_drive;

	always_comb begin
		// System-error driver stays off unless bit 8 and bit 6 are both on somewhere; parity-error driver needs bit 6 only
		next_serr_drive = addr_parity_err_i & syserr_any & parity_any;
		next_perr_drive = (|data_parity_err_i) & parity_any;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serr_drive <= 1'b0;
			perr_drive <= 1'b0;
		end else begin
			serr_drive <= next_serr_drive;
			perr_drive <= next_perr_drive;
		end
	end

	// Open drain: level low while enabled, released otherwise
	assign serr_n_o = 1'b0;
	assign serr_oe_n_o = ~serr_drive;
	assign perr_n_o = 1'b0;
	assign perr_oe_n_o = ~perr_drive;

endmodule

// [verification/pci_function_command_register_tb.sv]
`timescale 1ns/10ps
module pci_function_command_register_tb;
	logic sys_clk_i, rst_n_i, cfg_ack_o, addr_parity_err_i, perr_seen_i;
	logic serr_n_o, serr_oe_n_o, perr_n_o, perr_oe_n_o, serr_line, perr_line;
	pfcr_pkg::pfcr_cfg_req_t cfg_req_i;
	logic [31:0] cfg_rdata_o, lfsr_s, r;
	logic [1:0] io_hit_i, mem_hit_i, palette_write_i, master_req_i, master_active_i;
	logic [1:0] data_parity_err_i, io_claim_o, mem_claim_o, palette_capture_o;
	logic [1:0] bus_request_o, write_invalidate_o;
	logic [15:0] ctl [2];
	logic flg [2];
	int errors, n_compared;
	pfcr_top DUT (.sys_clk_i, .rst_n_i, .cfg_req_i, .cfg_ack_o, .cfg_rdata_o, .io_hit_i,
		.mem_hit_i, .palette_write_i, .master_req_i, .master_active_i, .addr_parity_err_i,
		.data_parity_err_i, .perr_seen_i, .io_claim_o, .mem_claim_o, .palette_capture_o,
		.bus_request_o, .write_invalidate_o, .serr_n_o, .serr_oe_n_o, .perr_n_o, .perr_oe_n_o);
	pfcr_od_line u_serr (.val_i(serr_n_o), .oe_n_i(serr_oe_n_o), .line_o(serr_line));
	pfcr_od_line u_perr (.val_i(perr_n_o), .oe_n_i(perr_oe_n_o), .line_o(perr_line));
	always #10 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////
	function automatic logic [31:0] lfsr();
		lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
		return lfsr_s;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Request held until the next call or traffic, so transfers may run back to back
	task automatic cfg(input logic w, input logic [3:0] f, input logic [7:0] off,
			input logic [3:0] be, input logic [31:0] d);
		logic [31:0] e;
		cfg_req_i = {w, !w, f, off, be, d};
		e = 32'h0;
		if (f < 2 && off[7:2] == 6'h01) begin
			if (w && be[0]) ctl[f][7:0] = d[7:0] & 8'h67;
			if (w && be[1]) ctl[f][8] = d[8];
			if (w && be[3] && d[24]) flg[f] = 1'b0;
			e = {7'h00, flg[f], 8'h00, ctl[f]};
		end
		@(negedge sys_clk_i);
		chk("ack", cfg_ack_o, 32'h1);
		if (!w) chk("rdata", cfg_rdata_o, e);
	endtask
	task automatic traffic(input int n);
		logic [1:0] e_io, e_mem, e_cap, e_req;
		logic o8, o6;
		cfg_req_i = '0;
		repeat (n) begin
			r = lfsr();
			{io_hit_i, mem_hit_i, palette_write_i, master_req_i, master_active_i} = r[9:0];
			{addr_parity_err_i, data_parity_err_i, perr_seen_i} = r[13:10];
			o8 = ctl[0][8] | ctl[1][8];
			o6 = ctl[0][6] | ctl[1][6];
			for (int f = 0; f < 2; f++) begin
				e_io[f] = ctl[f][0] & (io_hit_i[f] | palette_write_i[f]);
				e_io[f] = e_io[f] & ~(palette_write_i[f] & ctl[f][5]);
				e_cap[f] = palette_write_i[f] & ctl[f][5];
				e_mem[f] = ctl[f][1] & mem_hit_i[f];
				e_req[f] = ctl[f][2] & master_req_i[f];
				if (perr_seen_i & master_active_i[f] & ctl[f][6]) flg[f] = 1'b1;
			end
			@(negedge sys_clk_i);
			chk("io_claim", io_claim_o, e_io);
			chk("palette_capture", palette_capture_o, e_cap);
			chk("mem_claim", mem_claim_o, e_mem);
			chk("bus_request", bus_request_o, e_req);
			chk("write_invalidate", write_invalidate_o, 32'h0);
			chk("serr_line", serr_line, !(addr_parity_err_i & o8 & o6));
			chk("perr_line", perr_line, !((|data_parity_err_i) & o6));
		end
		{io_hit_i, mem_hit_i, palette_write_i, master_req_i, master_active_i} = '0;
		{addr_parity_err_i, data_parity_err_i, perr_seen_i} = '0;
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		rst_n_i = 1'b0;
		lfsr_s = 32'hC0842153;
		ctl = '{16'h0000, 16'h0000};
		flg = '{1'b0, 1'b0};
		traffic(0);
		repeat (8) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		cfg(0, 4'h0, 8'h04, 4'hF, 32'h0);
		cfg(0, 4'h1, 8'h04, 4'hF, 32'h0);
		traffic(20);
		cfg(1, 4'h0, 8'h04, 4'h3, 32'hFFFFFFFF);
		cfg(0, 4'h0, 8'h04, 4'hF, 32'h0);
		cfg(0, 4'h1, 8'h04, 4'hF, 32'h0);
		traffic(40);
		repeat (60) begin
			r = lfsr();
			cfg(1, {2'h0, r[1:0]}, r[2] ? 8'h08 : 8'h04, r[7:4], lfsr());
			cfg(0, {2'h0, r[9:8]}, r[10] ? 8'h08 : 8'h04, 4'hF, 32'h0);
			traffic(10);
		end
		complete_run();
	end
	// Span well beyond the roughly 800 cycles the sequence needs
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule

// [verification/pfcr_od_line.sv]
`timescale 1ns/10ps
// Bus line with pull-up: high whenever nobody drives
module pfcr_od_line (
	// Driver side
	input wire logic val_i,
	input wire logic oe_n_i,
	// Resolved level
	output logic line_o
);
	assign line_o = oe_n_i ? 1'b1 : val_i;
endmodule

// [verification/pfcr_top_props.sv]
`timescale 1ns/10ps
module pfcr_top_props #(parameter int NUM_FUNC = 2) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Configuration access
	input pfcr_pkg::pfcr_cfg_req_t cfg_req_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	// Decode inputs and gated outputs
	input wire logic [NUM_FUNC-1:0] io_hit_i,
	input wire logic [NUM_FUNC-1:0] mem_hit_i,
	input wire logic [NUM_FUNC-1:0] palette_write_i,
	input wire logic [NUM_FUNC-1:0] master_req_i,
	input wire logic [NUM_FUNC-1:0] io_claim_o,
	input wire logic [NUM_FUNC-1:0] mem_claim_o,
	input wire logic [NUM_FUNC-1:0] palette_capture_o,
	input wire logic [NUM_FUNC-1:0] bus_request_o,
	input wire logic [NUM_FUNC-1:0] write_invalidate_o,
	// Errors
	input wire logic addr_parity_err_i,
	input wire logic [NUM_FUNC-1:0] data_parity_err_i,
	input wire logic serr_n_o,
	input wire logic serr_oe_n_o,
	input wire logic perr_n_o,
	input wire logic perr_oe_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence read_answer;
		$past(cfg_req_i.read) ##0 cfg_ack_o;
	endsequence
	////////////////////////////////////////
	chk_ro_zero: assert property
		(read_answer |-> (cfg_rdata_o & 32'hFEFFFE98) == 32'h0)
		else $error("read-only bits not zero");
	chk_no_invalidate: assert property (write_invalidate_o == '0)
		else $error("write invalidate raised");
	chk_mem_gate: assert property ((mem_claim_o & ~$past(mem_hit_i)) == '0)
		else $error("memory claim without hit");
	chk_io_gate: assert property
		((io_claim_o & ~($past(io_hit_i) | $past(palette_write_i))) == '0)
		else $error("io claim without hit");
	chk_master_gate: assert property ((bus_request_o & ~$past(master_req_i)) == '0)
		else $error("bus request without master request");
	chk_snoop_quiet: assert property
		((palette_capture_o & (io_claim_o | ~$past(palette_write_i))) == '0)
		else $error("palette capture wrong");
	chk_serr_cause: assert property (!serr_oe_n_o |-> $past(addr_parity_err_i))
		else $error("system error without address parity");
	chk_perr_cause: assert property (!perr_oe_n_o |-> |$past(data_parity_err_i))
		else $error("parity error without data parity");
	chk_pin_low: assert property (serr_n_o == 1'b0 && perr_n_o == 1'b0)
		else $error("open-drain value not low");
endmodule
bind pfcr_top pfcr_top_props #(.NUM_FUNC(NUM_FUNC)) u_props (.sys_clk_i, .rst_n_i, .cfg_req_i,
	.cfg_ack_o, .cfg_rdata_o, .io_hit_i, .mem_hit_i, .palette_write_i, .master_req_i,
	.io_claim_o, .mem_claim_o, .palette_capture_o, .bus_request_o, .write_invalidate_o,
	.addr_parity_err_i, .data_parity_err_i, .serr_n_o, .serr_oe_n_o, .perr_n_o, .perr_oe_n_o);
